// File: verilog/smf_ctrl.v
// Behaviour
// - enable subcommand turns smart on
// - no monitoring or full attribute saving before enable
// - enable state kept in nonvolatile store
// - repeated enable leaves attributes untouched
// - disable subcommand stops attribute monitoring
// - power-mode attribute saved even when disabled
// - disabled: abort all but enable subcommand
// - volatile attributes flushed to sectors on disable
// - re-enable refreshes on next read or save
// - return status saves, compares, then reports
// - sector count zero disables auto off-line
// - sector count enable code enables auto off-line
// - enabling may start or resume off-line activity
// - read scanning follows the same switch
// - power and error events may still save
// - other codes keep settings, abort
`timescale 1ns/10ps
`default_nettype none
`include "smf_consts.vh"

module smf_ctrl #(
	parameter NUM_ATTR = 30,
	parameter IW = 5,
	parameter AW = 8
) (
	input wire clk_sys,
	input wire srst,
	input wire cmd_wr,
	input wire [7:0] cmd_code,
	input wire [7:0] feat_in,
	input wire [7:0] seccnt_in,
	input wire attr_upd,
	input wire pwr_mode_upd,
	input wire evt_pwr_on,
	input wire evt_pwr_off,
	input wire evt_err_rec,
	input wire sav_done,
	input wire [AW-1:0] attr_val,
	input wire [AW-1:0] attr_thr,
	input wire nv_rd_ack,
	input wire [`SMF_NV_W-1:0] nv_rd_data,
	input wire nv_wr_ack,
	output reg sts_bsy_r,
	output reg sts_err_r,
	output reg [7:0] err_reg_r,
	output reg cmd_done_r,
	output reg [7:0] lba_mid_r,
	output reg [7:0] lba_hi_r,
	output reg smart_en_r,
	output reg offl_en_r,
	output reg scan_en_r,
	output reg offl_go_r,
	output reg fwd_r,
	output reg [7:0] fwd_sub_r,
	output reg sav_req_r,
	output reg sav_all_r,
	output wire [IW-1:0] attr_idx,
	output wire nv_rd_req,
	output wire nv_wr_req,
	output wire [`SMF_NV_W-1:0] nv_wr_data
);

// ----------------------------------------------------------------------
// states
// ----------------------------------------------------------------------
localparam [2:0] S_LOAD = 3'h0;
localparam [2:0] S_IDLE = 3'h1;
localparam [2:0] S_SAVE = 3'h2;
localparam [2:0] S_CMP = 3'h3;
localparam [2:0] S_NVW = 3'h4;
localparam [2:0] S_DONE = 3'h5;

reg [2:0] state_r;
reg [7:0] sub_r;
reg abrt_r;
reg bg_r;
reg bg_pend_r;
reg dirty_r;
reg pwr_dirty_r;
reg refresh_r;
reg nv_go_r;
reg nv_sent_r;
reg cmp_go_r;

wire ld_done;
wire [`SMF_NV_W-1:0] ld_bits;
wire wr_done;
wire cmp_done;
wire cmp_fail;
wire smart_cmd;
wire bg_evt;
wire [`SMF_NV_W-1:0] nv_bits;

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
// subcommands whose data phase is served outside this block
function smf_is_fwd;
	input [7:0] sub;
	begin
		smf_is_fwd = (sub == `SMF_SUB_OFFL_NOW) ||
			(sub == `SMF_SUB_LOG_RD) ||
			(sub == `SMF_SUB_LOG_WR);
	end
endfunction

// subcommands that carry a pending attribute refresh
function smf_is_attr_io;
	input [7:0] sub;
	begin
		smf_is_attr_io = (sub == `SMF_SUB_READ) || (sub == `SMF_SUB_SAVE);
	end
endfunction

assign smart_cmd = cmd_wr && (cmd_code == `SMF_CMD_SMART);
assign bg_evt = evt_pwr_on || evt_pwr_off || evt_err_rec;

// ----------------------------------------------------------------------
// nonvolatile settings word
// ----------------------------------------------------------------------
assign nv_bits[`SMF_NV_EN] = smart_en_r;
assign nv_bits[`SMF_NV_OFFL] = offl_en_r;
assign nv_bits[`SMF_NV_SCAN] = scan_en_r;

smf_nv_store #(
	.W(`SMF_NV_W)
) u_nv (
	.clk_sys(clk_sys),
	.srst(srst),
	.ld_done_r(ld_done),
	.ld_bits_r(ld_bits),
	.wr_go(nv_go_r),
	.wr_bits(nv_bits),
	.wr_done_r(wr_done),
	.nv_rd_req_r(nv_rd_req),
	.nv_rd_ack(nv_rd_ack),
	.nv_rd_data(nv_rd_data),
	.nv_wr_req_r(nv_wr_req),
	.nv_wr_data_r(nv_wr_data),
	.nv_wr_ack(nv_wr_ack)
);

// ----------------------------------------------------------------------
// threshold comparator
// ----------------------------------------------------------------------
smf_thr_cmp #(
	.NUM_ATTR(NUM_ATTR),
	.IW(IW),
	.W(AW)
) u_cmp (
	.clk_sys(clk_sys),
	.srst(srst),
	.start(cmp_go_r),
	.idx_r(attr_idx),
	.val(attr_val),
	.thr(attr_thr),
	.done_r(cmp_done),
	.fail_r(cmp_fail)
);

// ----------------------------------------------------------------------
// command sequencer
// ----------------------------------------------------------------------
always @(posedge clk_sys) begin
	if (srst) begin
		state_r <= S_LOAD;
		sub_r <= 8'h00;
		abrt_r <= 1'b0;
		bg_r <= 1'b0;
		bg_pend_r <= 1'b0;
		dirty_r <= 1'b0;
		pwr_dirty_r <= 1'b0;
		refresh_r <= 1'b0;
		nv_go_r <= 1'b0;
		nv_sent_r <= 1'b0;
		cmp_go_r <= 1'b0;
		sts_bsy_r <= 1'b1;
		sts_err_r <= 1'b0;
		err_reg_r <= `SMF_ERR_NONE;
		cmd_done_r <= 1'b0;
		lba_mid_r <= `SMF_LBA_RST;
		lba_hi_r <= `SMF_LBA_RST;
		smart_en_r <= 1'b0;
		offl_en_r <= 1'b0;
		scan_en_r <= 1'b0;
		offl_go_r <= 1'b0;
		fwd_r <= 1'b0;
		fwd_sub_r <= 8'h00;
		sav_req_r <= 1'b0;
		sav_all_r <= 1'b0;
	end else begin
		cmd_done_r <= 1'b0;
		offl_go_r <= 1'b0;
		fwd_r <= 1'b0;
		nv_go_r <= 1'b0;
		cmp_go_r <= 1'b0;
		case (state_r)
		S_LOAD: begin
			// settings restored from the store before any command
			if (ld_done) begin
				smart_en_r <= ld_bits[`SMF_NV_EN];
				offl_en_r <= ld_bits[`SMF_NV_OFFL];
				scan_en_r <= ld_bits[`SMF_NV_SCAN];
				offl_go_r <= ld_bits[`SMF_NV_OFFL];
				sts_bsy_r <= 1'b0;
				state_r <= S_IDLE;
			end
		end
		S_IDLE: begin
			if (smart_cmd) begin
				sub_r <= feat_in;
				sts_bsy_r <= 1'b1;
				sts_err_r <= 1'b0;
				err_reg_r <= `SMF_ERR_NONE;
				abrt_r <= 1'b0;
				bg_r <= 1'b0;
				if (!smart_en_r && feat_in != `SMF_SUB_ENABLE) begin
					abrt_r <= 1'b1;
					state_r <= S_DONE;
				end else begin
					case (feat_in)
					`SMF_SUB_ENABLE: begin
						// already on: attribute state left alone
						if (!smart_en_r)
							refresh_r <= 1'b1;
						smart_en_r <= 1'b1;
						state_r <= S_NVW;
					end
					`SMF_SUB_DISABLE: begin
						state_r <= S_SAVE;
					end
					`SMF_SUB_STATUS: begin
						state_r <= S_SAVE;
					end
					`SMF_SUB_AUTO: begin
						if (seccnt_in == `SMF_AUTO_OFF) begin
							offl_en_r <= 1'b0;
							scan_en_r <= 1'b0;
							state_r <= S_NVW;
						end else if (seccnt_in == `SMF_AUTO_ON) begin
							offl_en_r <= 1'b1;
							scan_en_r <= 1'b1;
							offl_go_r <= 1'b1;
							state_r <= S_NVW;
						end else begin
							abrt_r <= 1'b1;
							state_r <= S_DONE;
						end
					end
					default: begin
						if (smf_is_attr_io(feat_in)) begin
							if (refresh_r || dirty_r)
								state_r <= S_SAVE;
							else
								state_r <= S_DONE;
						end else if (smf_is_fwd(feat_in)) begin
							fwd_r <= 1'b1;
							fwd_sub_r <= feat_in;
							state_r <= S_DONE;
						end else begin
							abrt_r <= 1'b1;
							state_r <= S_DONE;
						end
					end
					endcase
				end
			end else if (bg_pend_r) begin
				bg_pend_r <= 1'b0;
				if (dirty_r || pwr_dirty_r) begin
					bg_r <= 1'b1;
					state_r <= S_SAVE;
				end
			end
		end
		S_SAVE: begin
			// disabled: only the power-mode attribute goes out
			sav_req_r <= 1'b1;
			sav_all_r <= smart_en_r;
			if (sav_req_r && sav_done) begin
				sav_req_r <= 1'b0;
				dirty_r <= 1'b0;
				pwr_dirty_r <= 1'b0;
				if (smart_en_r)
					refresh_r <= 1'b0;
				if (bg_r) begin
					bg_r <= 1'b0;
					state_r <= S_IDLE;
				end else begin
					case (sub_r)
					`SMF_SUB_DISABLE: begin
						smart_en_r <= 1'b0;
						state_r <= S_NVW;
					end
					`SMF_SUB_STATUS: begin
						cmp_go_r <= 1'b1;
						state_r <= S_CMP;
					end
					default: begin
						state_r <= S_DONE;
					end
					endcase
				end
			end
		end
		S_CMP: begin
			if (cmp_done) begin
				lba_mid_r <= cmp_fail ? `SMF_FAIL_MID : `SMF_OK_MID;
				lba_hi_r <= cmp_fail ? `SMF_FAIL_HI : `SMF_OK_HI;
				state_r <= S_DONE;
			end
		end
		S_NVW: begin
			if (!nv_sent_r) begin
				nv_go_r <= 1'b1;
				nv_sent_r <= 1'b1;
			end else if (wr_done) begin
				nv_sent_r <= 1'b0;
				state_r <= S_DONE;
			end
		end
		S_DONE: begin
			sts_bsy_r <= 1'b0;
			sts_err_r <= abrt_r;
			err_reg_r <= abrt_r ? `SMF_ERR_ABRT : `SMF_ERR_NONE;
			cmd_done_r <= 1'b1;
			state_r <= S_IDLE;
		end
		default: begin
			state_r <= S_IDLE;
		end
		endcase
		// event sets come last so they win over a clear in the same cycle
		if (attr_upd && smart_en_r)
			dirty_r <= 1'b1;
		if (pwr_mode_upd)
			pwr_dirty_r <= 1'b1;
		if (bg_evt)
			bg_pend_r <= 1'b1;
	end
end

endmodule
`default_nettype wire

// File: verilog/smf_consts.vh
`ifndef SMF_CONSTS_VH
`define SMF_CONSTS_VH

// ----------------------------------------------------------------------
// command and subcommand codes
// ----------------------------------------------------------------------
`define SMF_CMD_SMART 8'hB0
`define SMF_SUB_READ 8'hD0
`define SMF_SUB_SAVE 8'hD3
`define SMF_SUB_OFFL_NOW 8'hD4
`define SMF_SUB_LOG_RD 8'hD5
`define SMF_SUB_LOG_WR 8'hD6
`define SMF_SUB_ENABLE 8'hD8
`define SMF_SUB_DISABLE 8'hD9
`define SMF_SUB_STATUS 8'hDA
`define SMF_SUB_AUTO 8'hDB

// ----------------------------------------------------------------------
// sector count codes of the automatic off-line subcommand
// ----------------------------------------------------------------------
`define SMF_AUTO_OFF 8'h00
`define SMF_AUTO_ON 8'hF8

// ----------------------------------------------------------------------
// return status signatures in lba mid / lba high
// ----------------------------------------------------------------------
`define SMF_OK_MID 8'h4F
`define SMF_OK_HI 8'hC2
`define SMF_FAIL_MID 8'hF4
`define SMF_FAIL_HI 8'h2C

// ----------------------------------------------------------------------
// error and status fields
// ----------------------------------------------------------------------
`define SMF_ERR_ABRT 8'h04
`define SMF_ERR_NONE 8'h00
`define SMF_LBA_RST 8'h00

// ----------------------------------------------------------------------
// nonvolatile word layout and reset value
// ----------------------------------------------------------------------
`define SMF_NV_W 3
`define SMF_NV_EN 0
`define SMF_NV_OFFL 1
`define SMF_NV_SCAN 2
`define SMF_NV_RST 3'h0

`endif

// File: verilog/smf_nv_store.v
`timescale 1ns/10ps
`default_nettype none
`include "smf_consts.vh"

module smf_nv_store #(
	parameter W = `SMF_NV_W
) (
	input wire clk_sys,
	input wire srst,
	output reg ld_done_r,
	output reg [W-1:0] ld_bits_r,
	input wire wr_go,
	input wire [W-1:0] wr_bits,
	output reg wr_done_r,
	output reg nv_rd_req_r,
	input wire nv_rd_ack,
	input wire [W-1:0] nv_rd_data,
	output reg nv_wr_req_r,
	output reg [W-1:0] nv_wr_data_r,
	input wire nv_wr_ack
);

// ----------------------------------------------------------------------
// power-up restore, then write-through on request
// ----------------------------------------------------------------------
always @(posedge clk_sys) begin
	if (srst) begin
		ld_done_r <= 1'b0;
		ld_bits_r <= `SMF_NV_RST;
		wr_done_r <= 1'b0;
		nv_rd_req_r <= 1'b1;
		nv_wr_req_r <= 1'b0;
		nv_wr_data_r <= `SMF_NV_RST;
	end else begin
		ld_done_r <= 1'b0;
		wr_done_r <= 1'b0;
		if (nv_rd_req_r && nv_rd_ack) begin
			nv_rd_req_r <= 1'b0;
			ld_bits_r <= nv_rd_data;
			ld_done_r <= 1'b1;
		end
		if (wr_go && !nv_wr_req_r) begin
			nv_wr_req_r <= 1'b1;
			nv_wr_data_r <= wr_bits;
		end else if (nv_wr_req_r && nv_wr_ack) begin
			nv_wr_req_r <= 1'b0;
			wr_done_r <= 1'b1;
		end
	end
end

endmodule
`default_nettype wire

// File: verilog/smf_thr_cmp.v
`timescale 1ns/10ps
`default_nettype none

module smf_thr_cmp #(
	parameter NUM_ATTR = 30,
	parameter IW = 5,
	parameter W = 8
) (
	input wire clk_sys,
	input wire srst,
	input wire start,
	output reg [IW-1:0] idx_r,
	input wire [W-1:0] val,
	input wire [W-1:0] thr,
	output reg done_r,
	output reg fail_r
);

reg run_r;

// ----------------------------------------------------------------------
// walk all attributes; a zero threshold never trips
// ----------------------------------------------------------------------
always @(posedge clk_sys) begin
	if (srst) begin
		idx_r <= {IW{1'b0}};
		run_r <= 1'b0;
		done_r <= 1'b0;
		fail_r <= 1'b0;
	end else begin
		done_r <= 1'b0;
		if (start && !run_r) begin
			idx_r <= {IW{1'b0}};
			run_r <= 1'b1;
			fail_r <= 1'b0;
		end else if (run_r) begin
			if (thr != {W{1'b0}} && val <= thr)
				fail_r <= 1'b1;
			if (idx_r == NUM_ATTR[IW-1:0] - 1'b1) begin
				run_r <= 1'b0;
				done_r <= 1'b1;
			end else begin
				idx_r <= idx_r + 1'b1;
			end
		end
	end
end

endmodule
`default_nettype wire

// File: testbench/smf_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module smf_ctrl_chk (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] feat_in,
	input wire logic [7:0] seccnt_in,
	input wire logic sts_bsy_r,
	input wire logic sts_err_r,
	input wire logic [7:0] err_reg_r,
	input wire logic cmd_done_r,
	input wire logic smart_en_r,
	input wire logic offl_en_r,
	input wire logic scan_en_r,
	input wire logic offl_go_r,
	input wire logic sav_req_r,
	input wire logic sav_all_r,
	input wire logic nv_wr_req,
	input wire logic nv_wr_ack,
	input wire logic [2:0] nv_wr_data
);
	// ----------------------------------------
	// accepted command
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire logic take = cmd_wr && cmd_code == 8'hB0 && !sts_bsy_r;
	wire logic db = take && smart_en_r && feat_in == 8'hDB;
	sequence s_take_da;
		take && smart_en_r && feat_in == 8'hDA;
	endsequence
	sequence s_save_soon;
		##[1:3] sav_req_r;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_ENABLE: assert property (take && feat_in == 8'hD8 |=> smart_en_r)
		else $error("enable did not set smart state");
	AST_OFF_ABORT: assert property (take && !smart_en_r && feat_in != 8'hD8
		|-> ##2 cmd_done_r && sts_err_r && err_reg_r == 8'h04)
		else $error("subcommand not aborted while off");
	AST_AUTO_ON: assert property (db && seccnt_in == 8'hF8
		|=> offl_en_r && scan_en_r && offl_go_r)
		else $error("auto off-line not enabled");
	AST_AUTO_OFF: assert property (db && seccnt_in == 8'h00 |=> !offl_en_r && !scan_en_r)
		else $error("auto off-line not disabled");
	AST_AUTO_KEEP: assert property (take && feat_in == 8'hDB && seccnt_in != 8'h00
		&& seccnt_in != 8'hF8 |=> offl_en_r == $past(offl_en_r)
		&& scan_en_r == $past(scan_en_r))
		else $error("other code changed settings");
	AST_STATUS_SAVE: assert property (s_take_da |-> s_save_soon)
		else $error("status did not save first");
	AST_SAVE_ALL: assert property (sav_req_r && sav_all_r |-> smart_en_r)
		else $error("full save while off");
	AST_ABORT_CODE: assert property (cmd_done_r && sts_err_r |-> err_reg_r == 8'h04)
		else $error("abort code wrong");
	AST_DONE_IDLE: assert property (cmd_done_r |-> !sts_bsy_r)
		else $error("busy at completion");
	AST_NV_HOLD: assert property (nv_wr_req && !nv_wr_ack
		|=> nv_wr_req && $stable(nv_wr_data))
		else $error("nv write dropped early");
endmodule
bind smf_ctrl smf_ctrl_chk chk_u (.clk_sys, .srst, .cmd_wr, .cmd_code, .feat_in,
	.seccnt_in, .sts_bsy_r, .sts_err_r, .err_reg_r, .cmd_done_r, .smart_en_r,
	.offl_en_r, .scan_en_r, .offl_go_r, .sav_req_r, .sav_all_r, .nv_wr_req,
	.nv_wr_ack, .nv_wr_data);
`default_nettype wire

// File: testbench/smf_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module smf_far_model (
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic fail_on,
	input wire logic nv_rd_req,
	input wire logic nv_wr_req,
	input wire logic [2:0] nv_wr_data,
	input wire logic sav_req_r,
	input wire logic [4:0] attr_idx,
	output logic nv_rd_ack,
	output logic nv_wr_ack,
	output logic sav_done,
	output logic [2:0] nv_rd_data,
	output logic [7:0] attr_val,
	output logic [7:0] attr_thr
);
	// nonvolatile word survives device reset
	logic [2:0] nv_q = 3'h0;
	logic [3:0] cnt = 4'h0;
	logic pend, go, rd_on, wr_on, sv_on;
	initial begin
		nv_rd_ack = 1'b0;
		nv_wr_ack = 1'b0;
		sav_done = 1'b0;
	end
	// requests not yet driven after power-up count as idle
	assign rd_on = nv_rd_req === 1'b1;
	assign wr_on = nv_wr_req === 1'b1;
	assign sv_on = sav_req_r === 1'b1;
	assign pend = rd_on | wr_on | sv_on;
	assign go = pend && !(nv_rd_ack | nv_wr_ack | sav_done) && cnt >= (slow ? 4'h4 : 4'h0);
	always @(posedge clk_sys) begin
		cnt <= (go || !pend) ? 4'h0 : cnt + 4'h1;
		nv_rd_ack <= go && rd_on;
		nv_wr_ack <= go && !rd_on && wr_on;
		sav_done <= go && !rd_on && !wr_on && sv_on;
		if (go && !rd_on && wr_on) nv_q <= nv_wr_data;
	end
	// data not valid outside the ack shows the inverse
	assign nv_rd_data = nv_rd_ack ? nv_q : ~nv_q;
	assign attr_val = 8'h10 + {3'h0, attr_idx};
	assign attr_thr = (fail_on && attr_idx == 5'h07) ? attr_val : 8'h05;
endmodule
`default_nettype wire

// File: testbench/tb_smart_feature_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_smart_feature_control;
	logic clk_sys, srst, cmd_wr, attr_upd, pwr_mode_upd, evt_pwr_on, evt_pwr_off;
	logic evt_err_rec, sav_done, nv_rd_ack, nv_wr_ack, slow, fail_on;
	logic [7:0] cmd_code, feat_in, seccnt_in, attr_val, attr_thr;
	logic [2:0] nv_rd_data, nv_wr_data;
	logic sts_bsy_r, sts_err_r, cmd_done_r, smart_en_r, offl_en_r, scan_en_r, offl_go_r;
	logic fwd_r, sav_req_r, sav_all_r, nv_rd_req, nv_wr_req;
	logic [7:0] err_reg_r, lba_mid_r, lba_hi_r, fwd_sub_r;
	logic [4:0] attr_idx;
	int sav_seen = 0;
	int base = 0;
	logic [7:0] fwd_seen = 8'h00;
	logic last_all = 1'b0;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	// feature, sector count, {error, smart on, auto off-line on}
	logic [18:0] rows [14] = '{
		{8'hD0, 8'h00, 3'h4},
		{8'hD8, 8'h00, 3'h2},
		{8'hDB, 8'hF8, 3'h3},
		{8'hDB, 8'h55, 3'h7},
		{8'hDB, 8'h00, 3'h2},
		{8'hD4, 8'h00, 3'h2},
		{8'hD3, 8'h00, 3'h2},
		{8'hD8, 8'h00, 3'h2},
		{8'hD9, 8'h00, 3'h0},
		{8'hDA, 8'h00, 3'h4},
		{8'hDB, 8'hF8, 3'h4},
		{8'hD8, 8'h00, 3'h2},
		{8'hD0, 8'h00, 3'h2},
		{8'hEE, 8'h00, 3'h6}
	};
	smf_ctrl dut_u (.clk_sys, .srst, .cmd_wr, .cmd_code, .feat_in, .seccnt_in,
		.attr_upd, .pwr_mode_upd, .evt_pwr_on, .evt_pwr_off, .evt_err_rec, .sav_done,
		.attr_val, .attr_thr, .nv_rd_ack, .nv_rd_data, .nv_wr_ack, .sts_bsy_r,
		.sts_err_r, .err_reg_r, .cmd_done_r, .lba_mid_r, .lba_hi_r, .smart_en_r,
		.offl_en_r, .scan_en_r, .offl_go_r, .fwd_r, .fwd_sub_r, .sav_req_r,
		.sav_all_r, .attr_idx, .nv_rd_req, .nv_wr_req, .nv_wr_data);
	smf_far_model far_u (.clk_sys, .slow, .fail_on, .nv_rd_req, .nv_wr_req,
		.nv_wr_data, .sav_req_r, .attr_idx, .nv_rd_ack, .nv_wr_ack, .sav_done,
		.nv_rd_data, .attr_val, .attr_thr);
	// ----------------------------------------
	// clock, watchdog, save monitor
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (sav_req_r === 1'b1) begin
			sav_seen <= sav_seen + 1;
			last_all <= sav_all_r;
		end
		if (fwd_r === 1'b1)
			fwd_seen <= fwd_sub_r;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task cmd(input logic [7:0] f, input logic [7:0] s);
		cmd_wr = 1'b1;
		cmd_code = 8'hB0;
		feat_in = f;
		seccnt_in = s;
		@(negedge clk_sys);
		cmd_wr = 1'b0;
		repeat (300) if (cmd_done_r !== 1'b1) @(negedge clk_sys);
	endtask
	task reset_dev;
		srst = 1'b1;
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		repeat (300) if (sts_bsy_r !== 1'b0) @(negedge clk_sys);
	endtask
	task report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		{cmd_wr, attr_upd, pwr_mode_upd, evt_pwr_on, evt_pwr_off, evt_err_rec} = 6'h00;
		{cmd_code, feat_in, seccnt_in} = 24'h0000_00;
		{slow, fail_on} = 2'h0;
		@(negedge clk_sys);
		reset_dev();
		chk({sts_err_r, smart_en_r, offl_en_r, scan_en_r, 4'h0}, 8'h00);
		chk({nv_rd_req, nv_wr_req, cmd_done_r, sts_bsy_r, err_reg_r[3:0]}, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			cmd(rows[i][18:11], rows[i][10:3]);
			chk({sts_err_r, smart_en_r, offl_en_r, scan_en_r}, {rows[i][2:0], rows[i][0]});
			chk(err_reg_r, rows[i][2] ? 8'h04 : 8'h00);
		end
		chk(fwd_seen, 8'hD4);
		$display("test table done");
		base = sav_seen;
		slow = 1'b1;
		cmd(8'hDA, 8'h00);
		chk(lba_mid_r, 8'h4F);
		chk(lba_hi_r, 8'hC2);
		chk({7'h00, sav_seen != base}, 8'h01);
		fail_on = 1'b1;
		cmd(8'hDA, 8'h00);
		chk(lba_mid_r, 8'hF4);
		chk(lba_hi_r, 8'h2C);
		{slow, fail_on} = 2'h0;
		$display("test status done");
		base = sav_seen;
		cmd(8'hD0, 8'h00);
		chk({7'h00, sav_seen != base}, 8'h00);
		attr_upd = 1'b1;
		@(negedge clk_sys);
		attr_upd = 1'b0;
		cmd(8'hD0, 8'h00);
		chk({7'h00, sav_seen != base}, 8'h01);
		$display("test refresh done");
		cmd(8'hD9, 8'h00);
		base = sav_seen;
		{attr_upd, evt_err_rec} = 2'h3;
		@(negedge clk_sys);
		{attr_upd, evt_err_rec} = 2'h0;
		repeat (20) @(negedge clk_sys);
		chk({7'h00, sav_seen != base}, 8'h00);
		pwr_mode_upd = 1'b1;
		@(negedge clk_sys);
		pwr_mode_upd = 1'b0;
		evt_pwr_off = 1'b1;
		@(negedge clk_sys);
		evt_pwr_off = 1'b0;
		repeat (20) @(negedge clk_sys);
		chk({6'h00, sav_seen != base, last_all}, 8'h02);
		$display("test background done");
		cmd(8'hD8, 8'h00);
		cmd(8'hDB, 8'hF8);
		reset_dev();
		chk({smart_en_r, offl_en_r, scan_en_r}, 8'h07);
		$display("test power cycle done");
		report_and_stop();
	end
endmodule
`default_nettype wire
